// [adcc_cfg.svh]
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Register offsets on the plain register port
`define ADCC_OFS_RES_LO 3'h0
`define ADCC_OFS_RES_HI 3'h1
`define ADCC_OFS_CTRL0 3'h2
`define ADCC_OFS_CTRL1 3'h3
`define ADCC_OFS_CTRL2 3'h4
`define ADCC_OFS_PIN_LO 3'h5
`define ADCC_OFS_PIN_HI 3'h6

// Converter control 0 fields
`define ADCC_START_BIT 7
`define ADCC_BUSY_BIT 6
`define ADCC_EN_BIT 5
`define ADCC_FMT_BIT 4
`define ADCC_CH_MSB 3

// Converter control 1 fields
`define ADCC_SRC_MSB 7
`define ADCC_SRC_LSB 5
`define ADCC_DIV_MSB 2
`define ADCC_CTRL1_MASK 8'hE7

// Converter control 2 fields
`define ADCC_GAIN_BIT 7
`define ADCC_BG_BIT 6
`define ADCC_REFIN_BIT 5
`define ADCC_REFOUT_BIT 4
`define ADCC_REF_MSB 3

// Pin enable high register mask
`define ADCC_PIN_HI_MASK 8'h0F
`define ADCC_PIN_COUNT 12

// Reset values
`define ADCC_RESET_BYTE 8'h00
`define ADCC_RESET_RESULT 12'h000
`define ADCC_RESET_DIV 7'h00

// Code ranges
`define ADCC_CH_LAST 4'hB
`define ADCC_REF_EXT_FIRST 4'h1
`define ADCC_REF_EXT_LAST 4'h4
`define ADCC_REF_BG_FIRST 4'hA
`define ADCC_REF_BG_LAST 4'hC
`define ADCC_DIV_ALL 7'h7F

`endif

// [adcc_pkg.sv]
package adcc_pkg;
   typedef enum logic [0:0] {
      ADCC_IDLE = 1'b0,
      ADCC_BUSY = 1'b1
   } adcc_state_type;
endpackage

// [adcc_regs.sv]
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "adcc_cfg.svh"

// Overview of operation
// - Start bit high then low launches conversion
// - Busy flag set once conversion launched
// - Busy flag clears when conversion finishes
// - Disabled converter powered off, results kept
// - Format zero: left justified result
// - Format one: right justified result
// - Unused result bits read zero
// - Channel codes 0-11 valid, others float
// - Source 000/100 external, else internal only
// - Internal codes pick supply or reference ratio
// - Conversion clock divides by two to field
// - Reference codes bandgap multiples or supply
// - Supply or bandgap reference cuts pin
// - Analog pin drops digital and pull-high
// - Twelve pin enables across two registers
// - Unused bandgap switched off automatically
// - Internal reference needs gain amp enabled
// - Separate reference input and output pin enables
// - Unimplemented control bits read zero
// - Completion raises converter interrupt request
module adcc_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic lvd_lvr_enable,
   input wire logic conv_done_async,
   input wire logic [11:0] conv_result_async,
   output logic converter_power,
   output logic conv_start,
   output logic conv_clock_tick,
   output logic ext_channel_connect,
   output logic [3:0] ext_channel,
   output logic internal_connect,
   output logic [2:0] internal_source,
   output logic [3:0] ref_source_code,
   output logic ref_input_pin_connect,
   output logic ref_output_pin_enable,
   output logic bandgap_power,
   output logic gain_amp_power,
   output logic [11:0] pin_analog_mode,
   output logic conv_irq_req
);

   // Formats one result byte for the chosen justification
   function automatic logic [7:0] adcc_result_byte(input logic [11:0] res,
                                                    input logic fmt,
                                                    input logic high);
      logic [7:0] b;
      b = `ADCC_RESET_BYTE;
      if (high) begin
         b = fmt ? {4'h0, res[11:8]} : res[11:4];
      end else begin
         b = fmt ? res[7:0] : {res[3:0], 4'h0};
      end
      return b;
   endfunction

   function automatic logic adcc_is_external(input logic [2:0] src);
      return src[1:0] == 2'h0;
   endfunction

   adcc_pkg::adcc_state_type state, next_state;
   logic [7:0] ctrl0, next_ctrl0;
   logic [7:0] ctrl1, next_ctrl1;
   logic [7:0] ctrl2, next_ctrl2;
   logic [7:0] pin_lo, next_pin_lo;
   logic [7:0] pin_hi, next_pin_hi;
   logic [11:0] result, next_result;
   logic [7:0] next_rdata;
   logic launch, store;
   logic done_meta, done_sync, done_prev, done_edge;
   logic [11:0] res_meta, res_sync;
   logic [6:0] div_count, next_div_count;
   logic [6:0] div_mask;
   logic next_tick, next_start, next_irq;
   logic ext_src, ref_is_ext, ref_is_bg;
   logic next_power, next_ext_connect, next_int_connect, next_ref_in, next_ref_out;
   logic next_bandgap, next_gain;
   logic [3:0] next_ext_channel, next_ref_code;
   logic [2:0] next_int_source;
   logic [15:0] pin_all;

   // Converter is asynchronous; its done and data are double-registered first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_meta <= 1'b0;
         done_sync <= 1'b0;
         done_prev <= 1'b0;
         res_meta <= `ADCC_RESET_RESULT;
         res_sync <= `ADCC_RESET_RESULT;
      end else begin
         done_meta <= conv_done_async;
         done_sync <= done_meta;
         done_prev <= done_sync;
         res_meta <= conv_result_async;
         res_sync <= res_meta;
      end
   end

   assign done_edge = done_sync & ~done_prev;

   always_comb begin
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_pin_lo = pin_lo;
      next_pin_hi = pin_hi;
      launch = 1'b0;
      if (reg_write) begin
         case (reg_addr)
            `ADCC_OFS_CTRL0: begin
               next_ctrl0 = reg_wdata;
               // Busy is hardware state, never stored from software
               next_ctrl0[`ADCC_BUSY_BIT] = 1'b0;
               launch = ctrl0[`ADCC_START_BIT] & ~reg_wdata[`ADCC_START_BIT] &
                        reg_wdata[`ADCC_EN_BIT] & (state == adcc_pkg::ADCC_IDLE);
            end
            `ADCC_OFS_CTRL1: next_ctrl1 = reg_wdata & `ADCC_CTRL1_MASK;
            `ADCC_OFS_CTRL2: next_ctrl2 = reg_wdata;
            `ADCC_OFS_PIN_LO: next_pin_lo = reg_wdata;
            `ADCC_OFS_PIN_HI: next_pin_hi = reg_wdata & `ADCC_PIN_HI_MASK;
            default: next_ctrl0 = ctrl0;
         endcase
      end
   end

   // Restarts while busy are ignored; clearing enable aborts without a result
   always_comb begin
      next_state = state;
      store = 1'b0;
      case (state)
         adcc_pkg::ADCC_IDLE: begin
            if (launch) begin
               next_state = adcc_pkg::ADCC_BUSY;
            end
         end
         adcc_pkg::ADCC_BUSY: begin
            if (!ctrl0[`ADCC_EN_BIT]) begin
               next_state = adcc_pkg::ADCC_IDLE;
            end else if (done_edge) begin
               next_state = adcc_pkg::ADCC_IDLE;
               store = 1'b1;
            end
         end
         default: next_state = adcc_pkg::ADCC_IDLE;
      endcase
      next_result = store ? res_sync : result;
      next_start = launch;
      next_irq = store;
   end

   always_comb begin
      next_rdata = `ADCC_RESET_BYTE;
      if (reg_read) begin
         case (reg_addr)
            `ADCC_OFS_RES_LO: next_rdata = adcc_result_byte(result, ctrl0[`ADCC_FMT_BIT], 1'b0);
            `ADCC_OFS_RES_HI: next_rdata = adcc_result_byte(result, ctrl0[`ADCC_FMT_BIT], 1'b1);
            `ADCC_OFS_CTRL0: begin
               next_rdata = ctrl0;
               next_rdata[`ADCC_BUSY_BIT] = (state == adcc_pkg::ADCC_BUSY);
            end
            `ADCC_OFS_CTRL1: next_rdata = ctrl1;
            `ADCC_OFS_CTRL2: next_rdata = ctrl2;
            `ADCC_OFS_PIN_LO: next_rdata = pin_lo;
            `ADCC_OFS_PIN_HI: next_rdata = pin_hi;
            default: next_rdata = `ADCC_RESET_BYTE;
         endcase
      end
   end

   always_comb begin
      div_mask = ~(`ADCC_DIV_ALL << ctrl1[`ADCC_DIV_MSB:0]);
      next_div_count = ctrl0[`ADCC_EN_BIT] ? div_count + 7'h01 : `ADCC_RESET_DIV;
      next_tick = ctrl0[`ADCC_EN_BIT] & ((div_count & div_mask) == div_mask);
   end

   always_comb begin
      ext_src = adcc_is_external(ctrl1[`ADCC_SRC_MSB:`ADCC_SRC_LSB]);
      ref_is_ext = (ctrl2[`ADCC_REF_MSB:0] >= `ADCC_REF_EXT_FIRST) &&
                   (ctrl2[`ADCC_REF_MSB:0] <= `ADCC_REF_EXT_LAST);
      ref_is_bg = (ctrl2[`ADCC_REF_MSB:0] >= `ADCC_REF_BG_FIRST) &&
                  (ctrl2[`ADCC_REF_MSB:0] <= `ADCC_REF_BG_LAST);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= adcc_pkg::ADCC_IDLE;
         ctrl0 <= `ADCC_RESET_BYTE;
         ctrl1 <= `ADCC_RESET_BYTE;
         ctrl2 <= `ADCC_RESET_BYTE;
         pin_lo <= `ADCC_RESET_BYTE;
         pin_hi <= `ADCC_RESET_BYTE;
         result <= `ADCC_RESET_RESULT;
         reg_rdata <= `ADCC_RESET_BYTE;
         div_count <= `ADCC_RESET_DIV;
         conv_clock_tick <= 1'b0;
         conv_start <= 1'b0;
         conv_irq_req <= 1'b0;
      end else begin
         state <= next_state;
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         pin_lo <= next_pin_lo;
         pin_hi <= next_pin_hi;
         result <= next_result;
         reg_rdata <= next_rdata;
         div_count <= next_div_count;
         conv_clock_tick <= next_tick;
         conv_start <= next_start;
         conv_irq_req <= next_irq;
      end
   end

   // Analog routing is registered, so it follows a register write by one cycle
   always_comb begin
      next_power = ctrl0[`ADCC_EN_BIT];
      next_ext_connect = ext_src && (ctrl0[`ADCC_CH_MSB:0] <= `ADCC_CH_LAST);
      next_ext_channel = ctrl0[`ADCC_CH_MSB:0];
      next_int_connect = !ext_src && (!ctrl1[`ADCC_SRC_MSB] || ctrl2[`ADCC_GAIN_BIT]);
      next_int_source = ctrl1[`ADCC_SRC_MSB:`ADCC_SRC_LSB];
      next_ref_code = ctrl2[`ADCC_REF_MSB:0];
      next_ref_in = ref_is_ext && ctrl2[`ADCC_REFIN_BIT];
      next_ref_out = ctrl2[`ADCC_REFOUT_BIT];
      next_bandgap = (ctrl2[`ADCC_BG_BIT] && ref_is_bg) || lvd_lvr_enable;
      next_gain = ctrl2[`ADCC_GAIN_BIT];
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         converter_power <= 1'b0;
         ext_channel_connect <= 1'b0;
         ext_channel <= 4'h0;
         internal_connect <= 1'b0;
         internal_source <= 3'h0;
         ref_source_code <= 4'h0;
         ref_input_pin_connect <= 1'b0;
         ref_output_pin_enable <= 1'b0;
         bandgap_power <= 1'b0;
         gain_amp_power <= 1'b0;
      end else begin
         converter_power <= next_power;
         ext_channel_connect <= next_ext_connect;
         ext_channel <= next_ext_channel;
         internal_connect <= next_int_connect;
         internal_source <= next_int_source;
         ref_source_code <= next_ref_code;
         ref_input_pin_connect <= next_ref_in;
         ref_output_pin_enable <= next_ref_out;
         bandgap_power <= next_bandgap;
         gain_amp_power <= next_gain;
      end
   end

   // Upper bits of the high enable register are held at zero on write
   assign pin_all = {pin_hi, pin_lo};

   // one analog mode flop per pin
   generate
      for (genvar p = 0; p < `ADCC_PIN_COUNT; p++) begin : g_pin
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               pin_analog_mode[p] <= 1'b0;
            end else begin
               pin_analog_mode[p] <= pin_all[p];
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   busy_on_launch_a: assert property (launch |=> state == adcc_pkg::ADCC_BUSY && conv_start)
      else $error("busy or start missing after launch");
   start_launch_a: assert property (
         conv_start |-> $past(reg_write) && !$past(reg_wdata[`ADCC_START_BIT]))
      else $error("start pulse without start falling write");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("start pulse longer than one cycle");
   busy_clear_a: assert property (store |=> state == adcc_pkg::ADCC_IDLE)
      else $error("busy not cleared at completion");
   busy_read_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_CTRL0) |->
         reg_rdata[`ADCC_BUSY_BIT] == $past(state == adcc_pkg::ADCC_BUSY))
      else $error("busy flag read back wrong");
   power_follow_a: assert property (converter_power == $past(ctrl0[`ADCC_EN_BIT]))
      else $error("converter power does not follow enable");
   abort_idle_a: assert property (
         state == adcc_pkg::ADCC_BUSY && !ctrl0[`ADCC_EN_BIT] |=> state == adcc_pkg::ADCC_IDLE)
      else $error("disabled converter stays busy");
   result_load_a: assert property (store |=> result == $past(res_sync) && conv_irq_req)
      else $error("result or request not updated at completion");
   disabled_hold_a: assert property (!ctrl0[`ADCC_EN_BIT] |=> $stable(result) && !converter_power)
      else $error("result changed or power on while disabled");
   irq_pulse_a: assert property (conv_irq_req |-> $past(state) == adcc_pkg::ADCC_BUSY ##1 !conv_irq_req)
      else $error("interrupt request not a completion pulse");
   ext_route_a: assert property (ext_channel_connect |-> ext_channel <= `ADCC_CH_LAST && !internal_connect)
      else $error("invalid external channel connected");
   ref_pin_a: assert property (ref_input_pin_connect |-> $past(ref_is_ext))
      else $error("reference pin connected for supply or bandgap");
   gain_gate_a: assert property (internal_connect && internal_source[2] |-> gain_amp_power)
      else $error("internal reference routed without gain amp");
   ctrl1_zero_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_CTRL1) |-> reg_rdata[4:3] == 2'h0)
      else $error("unimplemented control bits read nonzero");
   pin_hi_zero_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_PIN_HI) |-> reg_rdata[7:4] == 4'h0)
      else $error("unimplemented pin enable bits read nonzero");
   fmt_zero_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_RES_LO && !ctrl0[`ADCC_FMT_BIT]) |->
         reg_rdata[3:0] == 4'h0)
      else $error("unused result bits read nonzero");
   right_zero_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_RES_HI && ctrl0[`ADCC_FMT_BIT]) |->
         reg_rdata[7:4] == 4'h0)
      else $error("unused high result bits read nonzero");
   left_high_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_RES_HI && !ctrl0[`ADCC_FMT_BIT]) |->
         reg_rdata == $past(result[11:4]))
      else $error("left justified high byte wrong");
   right_low_a: assert property (
         $past(reg_read && reg_addr == `ADCC_OFS_RES_LO && ctrl0[`ADCC_FMT_BIT]) |->
         reg_rdata == $past(result[7:0]))
      else $error("right justified low byte wrong");

   ext_source_a: assert property (ext_channel_connect |-> adcc_is_external(internal_source))
      else $error("external channel connected for internal source");
   int_excl_a: assert property (
         internal_connect |-> !ext_channel_connect && internal_source[1:0] != 2'h0)
      else $error("internal signal routed with external channel");
   ref_code_a: assert property (ref_source_code == $past(ctrl2[`ADCC_REF_MSB:0]))
      else $error("reference code not passed on");
   bandgap_auto_a: assert property (
         bandgap_power |-> $past(lvd_lvr_enable || (ref_is_bg && ctrl2[`ADCC_BG_BIT])))
      else $error("bandgap powered while unused");
   gain_follow_a: assert property (gain_amp_power == $past(ctrl2[`ADCC_GAIN_BIT]))
      else $error("gain amp power does not follow enable");
   ref_out_a: assert property (ref_output_pin_enable == $past(ctrl2[`ADCC_REFOUT_BIT]))
      else $error("reference output pin does not follow enable");
   pin_mode_a: assert property (pin_analog_mode == $past(pin_all[11:0]))
      else $error("analog pin mode does not follow enables");
   tick_idle_a: assert property (!converter_power |-> !conv_clock_tick)
      else $error("conversion clock running while disabled");

   launch_c: cover property (launch ##1 conv_start);
   complete_c: cover property (store ##1 conv_irq_req);
   abort_c: cover property (state == adcc_pkg::ADCC_BUSY && !ctrl0[`ADCC_EN_BIT]);
   right_read_c: cover property (reg_read && reg_addr == `ADCC_OFS_RES_HI && ctrl0[`ADCC_FMT_BIT]);
   left_read_c: cover property (reg_read && reg_addr == `ADCC_OFS_RES_LO && !ctrl0[`ADCC_FMT_BIT]);

endmodule

// [adcc_regs_test.sv]
`timescale 1ns/1ps
`include "adcc_cfg.svh"

`define CHK(nm, exp, got) \
   begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module adcc_regs_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic lvd_lvr_enable = 1'b0;
   logic conv_done_async = 1'b0;
   logic [11:0] conv_result_async = 12'h000;
   logic converter_power, conv_start, conv_clock_tick, ext_channel_connect;
   logic [3:0] ext_channel;
   logic internal_connect;
   logic [2:0] internal_source;
   logic [3:0] ref_source_code;
   logic ref_input_pin_connect, ref_output_pin_enable, bandgap_power, gain_amp_power;
   logic [11:0] pin_analog_mode;
   logic conv_irq_req;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int cnt;
   logic seen;
   // Wait before a conversion once the bandgap is on; arbitrary but generous
   localparam int bandgap_settle_time = 20;

   adcc_regs i_adcc_regs (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .lvd_lvr_enable(lvd_lvr_enable),
      .conv_done_async(conv_done_async), .conv_result_async(conv_result_async),
      .converter_power(converter_power), .conv_start(conv_start),
      .conv_clock_tick(conv_clock_tick), .ext_channel_connect(ext_channel_connect),
      .ext_channel(ext_channel), .internal_connect(internal_connect),
      .internal_source(internal_source), .ref_source_code(ref_source_code),
      .ref_input_pin_connect(ref_input_pin_connect),
      .ref_output_pin_enable(ref_output_pin_enable), .bandgap_power(bandgap_power),
      .gain_amp_power(gain_amp_power), .pin_analog_mode(pin_analog_mode),
      .conv_irq_req(conv_irq_req));

   initial begin
      forever #20 clock = ~clock;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Whole run needs about 2400 cycles; the ceiling leaves ample margin
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      `CHK("read data", exp, reg_rdata)
   endtask

   // Routing outputs lag the register by one cycle
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask

   task automatic convert(input logic [11:0] d);
      @(posedge clock);
      conv_result_async <= d;
      conv_done_async <= 1'b1;
      seen = 1'b0;
      for (int n = 0; n < 10 && !seen; n++) begin
         @(posedge clock);
         #1;
         seen = (conv_irq_req === 1'b1);
      end
      @(posedge clock);
      conv_done_async <= 1'b0;
   endtask

   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 0; a < 8; a++) rdc(a[2:0], 8'h00);
      $display("test reset values done");

      wr(`ADCC_OFS_CTRL1, 8'hFF);
      rdc(`ADCC_OFS_CTRL1, 8'hE7);
      wr(`ADCC_OFS_PIN_HI, 8'hFF);
      rdc(`ADCC_OFS_PIN_HI, 8'h0F);
      wr(`ADCC_OFS_PIN_LO, 8'hA5);
      rdc(`ADCC_OFS_RES_HI, 8'h00);
      rdc(`ADCC_OFS_PIN_LO, 8'hA5);
      `CHK("pin mode", 12'hFA5, pin_analog_mode)
      wr(`ADCC_OFS_RES_LO, 8'hFF);
      rdc(`ADCC_OFS_RES_LO, 8'h00);
      $display("test masks and pins done");

      wr(`ADCC_OFS_CTRL1, 8'h00);
      wr(`ADCC_OFS_CTRL2, 8'h4A);
      repeat (bandgap_settle_time) @(posedge clock);
      wr(`ADCC_OFS_CTRL0, 8'hA0);
      wr(`ADCC_OFS_CTRL0, 8'h20);
      #1;
      `CHK("start pulse", 1'b1, conv_start)
      rdc(`ADCC_OFS_CTRL0, 8'h60);
      `CHK("power", 1'b1, converter_power)
      convert(12'hABC);
      `CHK("irq", 1'b1, seen)
      rdc(`ADCC_OFS_CTRL0, 8'h20);
      rdc(`ADCC_OFS_RES_HI, 8'hAB);
      rdc(`ADCC_OFS_RES_LO, 8'hC0);
      wr(`ADCC_OFS_CTRL0, 8'h30);
      rdc(`ADCC_OFS_RES_HI, 8'h0A);
      rdc(`ADCC_OFS_RES_LO, 8'hBC);
      wr(`ADCC_OFS_CTRL0, 8'h10);
      settle();
      `CHK("power off", 1'b0, converter_power)
      convert(12'h123);
      rdc(`ADCC_OFS_RES_LO, 8'hBC);
      rdc(`ADCC_OFS_RES_HI, 8'h0A);
      $display("test conversion done");

      for (int s = 0; s < 16; s++) begin
         wr(`ADCC_OFS_CTRL1, {s[2:0], 5'h00});
         wr(`ADCC_OFS_CTRL2, {s[3], 7'h00});
         wr(`ADCC_OFS_CTRL0, 8'h05);
         settle();
         `CHK("ext conn", (s[1:0] == 2'b00), ext_channel_connect)
         `CHK("int conn", (s[1:0] != 2'b00) && (!s[2] || s[3]), internal_connect)
         `CHK("source", s[2:0], internal_source)
         `CHK("channel", 4'h5, ext_channel)
         `CHK("gain amp", s[3], gain_amp_power)
      end
      wr(`ADCC_OFS_CTRL1, 8'h00);
      wr(`ADCC_OFS_CTRL0, 8'h0C);
      settle();
      `CHK("floating", 1'b0, ext_channel_connect)
      $display("test input routing done");

      for (int r = 0; r < 16; r++) begin
         wr(`ADCC_OFS_CTRL2, {2'b01, r[0], 1'b1, r[3:0]});
         settle();
         `CHK("ref code", r[3:0], ref_source_code)
         `CHK("ref pin", r[0] && r >= 1 && r <= 4, ref_input_pin_connect)
         `CHK("bandgap", r >= 10 && r <= 12, bandgap_power)
         `CHK("ref out", 1'b1, ref_output_pin_enable)
      end
      wr(`ADCC_OFS_CTRL2, 8'h00);
      @(posedge clock);
      lvd_lvr_enable <= 1'b1;
      settle();
      `CHK("bandgap lvd", 1'b1, bandgap_power)
      `CHK("ref out off", 1'b0, ref_output_pin_enable)
      @(posedge clock);
      lvd_lvr_enable <= 1'b0;
      settle();
      `CHK("bandgap off", 1'b0, bandgap_power)
      $display("test reference done");

      wr(`ADCC_OFS_CTRL0, 8'h20);
      for (int d = 0; d < 8; d++) begin
         wr(`ADCC_OFS_CTRL1, {5'h00, d[2:0]});
         repeat (4) @(posedge clock);
         cnt = 0;
         repeat (256) begin
            @(posedge clock);
            #1;
            if (conv_clock_tick === 1'b1) cnt++;
         end
         `CHK("ticks", 256 >> d, cnt)
      end
      $display("test clock divider done");
      finish_test();
   end
endmodule
